//--- core/spmpf_framer.sv
// packet framer: apb register file, word store and byte stream generator
//
// Behaviour
// - packet opens with bytes 00 ff 00 ff before any header field
// - header order: length, serial, status, rotation period, depth, reserved
// - length counts all bytes but checksum and padding; value 634
// - serial is four bytes, first two give the instrument type
// - status field carries no meaning
// - each group opens with a millisecond stamp counted from power-up
// - group carries eighteen channel words, nine absorption then nine attenuation
// - exactly ten groups of 56 bytes before the reference section
// - reference section: eighteen words, 54 bytes, same format and order
// - two-byte temperature word follows the reference section
// - four-byte checksum is the sum of all packet bytes, sync included
// - padding bytes follow the checksum; receiver ignores them
// - two-byte fields go low byte first
// - channel words go low byte, high byte, fraction byte
// - reference, temperature and status go out once per ten revolutions
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module spmpf_framer
  import spmpf_pkg::*;
#(
  parameter int          CYCLES_PER_MS = spmpf_pkg::CYCLES_PER_MS_DEF,
  parameter int          PAD_BYTES     = spmpf_pkg::PAD_BYTES_DEF,
  parameter logic [31:0] SERIAL_RESET  = 32'h0a0b_0001  // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  txByte,
  output logic             txValid,
  input  wire logic        txReady,
  output logic             busy
);
  import spmpf_pkg::*;

  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65535) begin : g_bad_ms
    $error("spmpf_framer: CYCLES_PER_MS out of range");
  end
  if (PAD_BYTES < 1 || (LEN_INT + CHK_BYTES + PAD_BYTES) > 1023) begin : g_bad_pad
    $error("spmpf_framer: PAD_BYTES out of range");
  end

  localparam logic [15:0] MS_LAST  = 16'(CYCLES_PER_MS - 1);
  localparam logic [9:0]  POS_LAST = 10'(LEN_INT + CHK_BYTES + PAD_BYTES - 1);

  spmpf_state_t    stateQ;
  logic [15:0]     msPreQ;
  logic [15:0]     msCountQ;
  logic [15:0]     stampQ [NUM_GROUPS];
  logic [31:0]     serialQ;
  logic [15:0]     rotQ;
  logic [15:0]     depthQ;
  logic [15:0]     tempQ;
  logic            repeatQ;
  logic [MEM_AW-1:0] waddrQ;
  logic [15:0]     pktCountQ;
  logic [31:0]     sumQ;
  logic [31:0]     lastSumQ;
  logic [9:0]      posQ;
  logic [MEM_AW-1:0] rdAddr;
  logic [23:0]     rdWord;
  logic [15:0]     curStamp;
  logic            memWr;
  logic            wrFire;
  logic            access;
  logic            startReq;
  logic            txFire;
  logic [31:0]     rdMux;
  logic            errMux;

  // which group a byte position lies in (data section only)
  function automatic int group_of(input logic [9:0] pos);
    return (int'(pos) - int'(POS_DATA)) / GROUP_BYTES;
  endfunction

  // word store index of the channel word a byte position belongs to
  function automatic logic [MEM_AW-1:0] word_addr(input logic [9:0] pos);
    int off;
    int idx;
    off = 0;
    idx = 0;
    if (pos >= POS_REF) begin
      off = int'(pos) - int'(POS_REF);
      idx = REF_BASE + off / WORD_BYTES;
    end else if (pos >= POS_DATA) begin
      off = (int'(pos) - int'(POS_DATA)) % GROUP_BYTES;
      if (off >= STAMP_BYTES) begin
        idx = group_of(pos) * NUM_CH + (off - STAMP_BYTES) / WORD_BYTES;
      end
    end
    return MEM_AW'(idx);
  endfunction

  // picks byte of a channel word: low, high, fraction
  function automatic logic [7:0] word_byte(input logic [23:0] w, input int sel);
    case (sel)
      0:       return w[15:8];
      1:       return w[23:16];
      default: return w[7:0];
    endcase
  endfunction

  // the byte sent at a given packet position
  function automatic logic [7:0] pkt_byte(input logic [9:0] pos, input logic [23:0] w,
                                          input logic [15:0] stamp,
                                          input logic [31:0] sum);
    int off;
    logic [7:0] b;
    off = 0;
    b   = 8'h00;
    if (pos < POS_LEN) begin
      b = pos[0] ? SYNC_HI : SYNC_LO;
    end else if (pos < POS_SER) begin
      b = pos[0] ? PKT_LEN[15:8] : PKT_LEN[7:0];
    end else if (pos < POS_STAT) begin
      off = int'(pos - POS_SER);
      b   = serialQ[8*(3-off) +: 8];
    end else if (pos < POS_ROT) begin
      b = 8'h00;
    end else if (pos < POS_DEP) begin
      b = pos[0] ? rotQ[15:8] : rotQ[7:0];
    end else if (pos < POS_RSV) begin
      b = pos[0] ? depthQ[15:8] : depthQ[7:0];
    end else if (pos < POS_DATA) begin
      b = 8'h00;
    end else if (pos < POS_REF) begin
      off = (int'(pos) - int'(POS_DATA)) % GROUP_BYTES;
      if (off < STAMP_BYTES) begin
        b = (off == 0) ? stamp[7:0] : stamp[15:8];
      end else begin
        b = word_byte(w, (off - STAMP_BYTES) % WORD_BYTES);
      end
    end else if (pos < POS_TEMP) begin
      off = int'(pos) - int'(POS_REF);
      b   = word_byte(w, off % WORD_BYTES);
    end else if (pos < POS_CHK) begin
      b = (pos == POS_TEMP) ? tempQ[7:0] : tempQ[15:8];
    end else if (pos < POS_PAD) begin
      off = int'(pos - POS_CHK);
      b   = sum[8*off +: 8];
    end else begin
      b = 8'h00;
    end
    return b;
  endfunction

  assign access   = psel && penable && !pready;
  assign wrFire   = psel && penable && pready && pwrite && !pslverr;
  assign startReq = wrFire && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT];
  assign txFire   = txValid && txReady;
  assign memWr    = wrFire && (paddr == OFS_WDATA);
  assign rdAddr   = word_addr(posQ);
  assign curStamp = (posQ >= POS_DATA && posQ < POS_REF) ? stampQ[group_of(posQ)] : 16'h0000;

  spmpf_word_mem #(
    .WIDTH (24),
    .DEPTH (MEM_WORDS),
    .AW    (MEM_AW)
  ) u_mem (
    .core_clk (core_clk),
    .ce       (ce),
    .wrEn     (memWr),
    .wrAddr   (waddrQ),
    .wrData   (pwdata[23:0]),
    .rdEn     (stateQ == ST_FETCH),
    .rdAddr   (rdAddr),
    .rdData   (rdWord)
  );

  // read mux and error decode; store writes refused while a packet is out
  always_comb begin
    rdMux  = 32'h0000_0000;
    errMux = 1'b0;
    case (paddr)
      OFS_CTRL:   rdMux = {30'h0, repeatQ, 1'b0};
      OFS_STATUS: rdMux = {pktCountQ, 14'h0, repeatQ, busy};
      OFS_SERIAL: rdMux = serialQ;
      OFS_ROT:    rdMux = {16'h0, rotQ};
      OFS_DEPTH:  rdMux = {16'h0, depthQ};
      OFS_TEMP:   rdMux = {16'h0, tempQ};
      OFS_STAMP: begin
        rdMux  = {16'h0, msCountQ};
        errMux = pwrite && (int'(pwdata[3:0]) >= NUM_GROUPS);
      end
      OFS_WADDR: begin
        rdMux  = {24'h0, waddrQ};
        errMux = pwrite && (int'(pwdata[MEM_AW-1:0]) >= MEM_WORDS);
      end
      OFS_WDATA:  errMux = pwrite && (busy || int'(waddrQ) >= MEM_WORDS);
      OFS_CHKSUM: rdMux = lastSumQ;
      default:    errMux = 1'b1;
    endcase
  end

  // one wait state: answer registered on the first access edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= access;
      pslverr <= access && errMux;
      if (access) begin
        prdata <= (pwrite || errMux) ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serialQ <= SERIAL_RESET;
      rotQ    <= 16'h0000;
      depthQ  <= 16'h0000;
      tempQ   <= 16'h0000;
      repeatQ <= 1'b0;
    end else if (ce && wrFire) begin
      case (paddr)
        OFS_CTRL:   repeatQ <= pwdata[CTRL_REPEAT_BIT];
        OFS_SERIAL: serialQ <= pwdata;
        OFS_ROT:    rotQ    <= pwdata[15:0];
        OFS_DEPTH:  depthQ  <= pwdata[15:0];
        OFS_TEMP:   tempQ   <= pwdata[15:0];
        default:    ;
      endcase
    end
  end

  // store write pointer, advances after each word written
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      waddrQ <= '0;
    end else if (ce && wrFire) begin
      if (paddr == OFS_WADDR) begin
        waddrQ <= pwdata[MEM_AW-1:0];
      end else if (paddr == OFS_WDATA) begin
        waddrQ <= waddrQ + MEM_AW'(1);
      end
    end
  end

  // millisecond counter from reset; wraps at 16 bits like the field
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      msPreQ   <= 16'h0000;
      msCountQ <= 16'h0000;
    end else if (ce) begin
      if (msPreQ == MS_LAST) begin
        msPreQ   <= 16'h0000;
        msCountQ <= msCountQ + 16'h0001;
      end else begin
        msPreQ <= msPreQ + 16'h0001;
      end
    end
  end

  // group stamps captured when software closes a revolution
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_GROUPS; i++) begin
        stampQ[i] <= 16'h0000;
      end
    end else if (ce && wrFire && paddr == OFS_STAMP) begin
      stampQ[pwdata[3:0]] <= msCountQ;
    end
  end

  // packet sequencer: fetch word, build byte, hand over
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= ST_IDLE;
      posQ   <= 10'h000;
      busy   <= 1'b0;
    end else if (ce) begin
      case (stateQ)
        ST_IDLE: begin
          if (startReq || repeatQ) begin
            posQ   <= 10'h000;
            busy   <= 1'b1;
            stateQ <= ST_FETCH;
          end
        end
        ST_FETCH: stateQ <= ST_LOAD;
        ST_LOAD:  stateQ <= ST_SEND;
        ST_SEND: begin
          if (txFire) begin
            if (posQ == POS_LAST) begin
              busy   <= 1'b0;
              stateQ <= ST_IDLE;
            end else begin
              posQ   <= posQ + 10'h001;
              stateQ <= ST_FETCH;
            end
          end
        end
        default: begin
          busy   <= 1'b0;
          stateQ <= ST_IDLE;
        end
      endcase
    end
  end

  // byte output register; held until the sink takes it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txByte  <= 8'h00;
      txValid <= 1'b0;
    end else if (ce) begin
      if (stateQ == ST_LOAD) begin
        txByte  <= pkt_byte(posQ, rdWord, curStamp, sumQ);
        txValid <= 1'b1;
      end else if (txFire) begin
        txValid <= 1'b0;
      end
    end
  end

  // running byte sum over sync, header and body only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sumQ      <= 32'h0000_0000;
      lastSumQ  <= 32'h0000_0000;
      pktCountQ <= 16'h0000;
    end else if (ce) begin
      if (stateQ == ST_IDLE) begin
        sumQ <= 32'h0000_0000;
      end else if (txFire && posQ < POS_CHK) begin
        sumQ <= sumQ + {24'h0, txByte};
      end
      if (txFire && posQ == POS_LAST) begin
        lastSumQ  <= sumQ;
        pktCountQ <= pktCountQ + 16'h0001;
      end
    end
  end
endmodule // spmpf_framer

//--- core/spmpf_pkg.sv
// constants, register map and state type for the spectral meter packet framer
package spmpf_pkg;

  // packet layout
  localparam logic [7:0] SYNC_LO      = 8'h00;
  localparam logic [7:0] SYNC_HI      = 8'hff;
  localparam int         SYNC_BYTES   = 4;
  localparam int         HDR_BYTES    = 18;
  localparam int         NUM_GROUPS   = 10;
  localparam int         NUM_CH       = 18;
  localparam int         WORD_BYTES   = 3;
  localparam int         STAMP_BYTES  = 2;
  localparam int         GROUP_BYTES  = STAMP_BYTES + NUM_CH * WORD_BYTES;
  localparam int         REF_BYTES    = NUM_CH * WORD_BYTES;
  localparam int         TEMP_BYTES   = 2;
  localparam int         CHK_BYTES    = 4;
  localparam int         LEN_INT      = HDR_BYTES + NUM_GROUPS * GROUP_BYTES + REF_BYTES
                                        + TEMP_BYTES;
  localparam logic [15:0] PKT_LEN     = 16'(LEN_INT);

  // byte positions inside a packet
  localparam logic [9:0] POS_LEN  = 10'(SYNC_BYTES);
  localparam logic [9:0] POS_SER  = 10'h006;
  localparam logic [9:0] POS_STAT = 10'h00a;
  localparam logic [9:0] POS_ROT  = 10'h00c;
  localparam logic [9:0] POS_DEP  = 10'h00e;
  localparam logic [9:0] POS_RSV  = 10'h010;
  localparam logic [9:0] POS_DATA = 10'(HDR_BYTES);
  localparam logic [9:0] POS_REF  = 10'(HDR_BYTES + NUM_GROUPS * GROUP_BYTES);
  localparam logic [9:0] POS_TEMP = 10'(HDR_BYTES + NUM_GROUPS * GROUP_BYTES + REF_BYTES);
  localparam logic [9:0] POS_CHK  = 10'(LEN_INT);
  localparam logic [9:0] POS_PAD  = 10'(LEN_INT + CHK_BYTES);

  // channel word store
  localparam int         MEM_WORDS = NUM_GROUPS * NUM_CH + NUM_CH;
  localparam int         MEM_AW    = 8;
  localparam int         REF_BASE  = NUM_GROUPS * NUM_CH;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SERIAL = 8'h08;
  localparam logic [7:0] OFS_ROT    = 8'h0c;
  localparam logic [7:0] OFS_DEPTH  = 8'h10;
  localparam logic [7:0] OFS_TEMP   = 8'h14;
  localparam logic [7:0] OFS_STAMP  = 8'h18;
  localparam logic [7:0] OFS_WADDR  = 8'h1c;
  localparam logic [7:0] OFS_WDATA  = 8'h20;
  localparam logic [7:0] OFS_CHKSUM = 8'h24;

  // field positions
  localparam int         CTRL_START_BIT  = 0;
  localparam int         CTRL_REPEAT_BIT = 1;
  localparam int         STAT_BUSY_BIT   = 0;
  localparam int         STAT_REPEAT_BIT = 1;
  localparam int         STAT_CNT_LSB    = 16;

  // timing
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         MS_NS           = 1000000;
  localparam int         CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int         PAD_BYTES_DEF   = 6;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_SEND  = 4'b1000
  } spmpf_state_t;

endpackage

//--- core/spmpf_word_mem.sv
// channel word store with registered read data
`timescale 1ns/1ps
module spmpf_word_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 198,
  parameter int AW    = 8
) (
  input  wire logic             core_clk,
  input  wire logic             ce,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             rdEn,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] memQ [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("spmpf_word_mem: DEPTH does not fit AW");
  end

  // no reset on the array: contents are software owned
  always_ff @(posedge core_clk) begin
    if (ce && wrEn && (int'(wrAddr) < DEPTH)) begin
      memQ[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && rdEn && (int'(rdAddr) < DEPTH)) begin
      rdData <= memQ[rdAddr];
    end
  end
endmodule // spmpf_word_mem

//--- dv/spmpf_framer_properties.sv
// port checker for the packet framer
`timescale 1ns/1ps
module spmpf_framer_properties
  import spmpf_pkg::*;
#(
  parameter int PAD_BYTES = 6
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  txByte,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        busy
);
  logic [9:0]  idx_q;
  logic [31:0] sum_q;
  logic        take;
  assign take = txValid && txReady;

  // byte index within the packet being sent
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) idx_q <= 10'h000;
    else if (!busy) idx_q <= 10'h000;
    else if (take) idx_q <= idx_q + 10'h001;
  end

  // running sum of every byte before the checksum
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) sum_q <= 32'h0;
    else if (!busy) sum_q <= 32'h0;
    else if (take && idx_q < POS_CHK) sum_q <= sum_q + {24'h0, txByte};
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_taken;
    ce && txValid && txReady;
  endsequence
  sequence s_gap;
    !txValid [*2];
  endsequence

  a_ready_wait: assert property (ce && psel && penable && !pready |=> pready)
    else $error("pready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_byte_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("byte changed while stalled");
  a_take_gap: assert property (s_taken |=> s_gap)
    else $error("next byte too early");
  a_sync_bytes: assert property (txValid && idx_q < 10'h004 |->
    txByte == (idx_q[0] ? 8'hff : 8'h00))
    else $error("sync pattern wrong");
  a_len_field: assert property (txValid && idx_q inside {10'h004, 10'h005} |->
    txByte == (idx_q[0] ? PKT_LEN[15:8] : PKT_LEN[7:0]))
    else $error("length field wrong");
  a_zero_fields: assert property (txValid && (idx_q inside {10'h00a, 10'h00b, 10'h010,
    10'h011} || idx_q >= POS_PAD) |-> txByte == 8'h00)
    else $error("unused field not zero");
  a_chk_low: assert property (txValid && idx_q == POS_CHK |-> txByte == sum_q[7:0])
    else $error("checksum low byte wrong");
  a_last_byte: assert property (take && idx_q == 10'(LEN_INT + CHK_BYTES + PAD_BYTES - 1)
    |=> !busy && !txValid)
    else $error("packet longer than expected");
endmodule // spmpf_framer_properties

bind spmpf_framer spmpf_framer_properties #(.PAD_BYTES(PAD_BYTES)) u_props (
  .core_clk(core_clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txByte(txByte), .txValid(txValid), .txReady(txReady), .busy(busy)
);

//--- dv/spmpf_host_sink.sv
// host data logger model: stalls, hunts sync, checks checksum
`timescale 1ns/1ps
module spmpf_host_sink #(
  parameter real DEPTH_SCALE  = 1.0,
  parameter real DEPTH_OFFSET = 0.0
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  input  wire logic       stall,
  output logic            txReady
);
  logic [7:0]  got[$];
  logic [31:0] win = 0;
  logic [31:0] sum = 0;
  logic [31:0] rx = 0;
  logic [15:0] len = 0;
  logic [15:0] rotationPeriodCount = 0;
  logic [15:0] depthCount = 0;
  logic [7:0]  wordLow = 0;
  real         scanRateValue = 0.0;
  real         depthMetres = 0.0;
  real         firstWord = 0.0;
  logic [1:0]  phase_q;
  logic        hunting = 1;
  int          cnt = 0;
  int          goodCount = 0;
  int          badCount = 0;

  // slow sink takes one cycle in four, so the framer must hold its byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 2'h0;
      txReady <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      txReady <= !stall || phase_q == 2'h3;
    end
  end

  always @(posedge core_clk) begin
    if (resetn && txValid && txReady) begin
      got.push_back(txByte);
      win = {win[23:0], txByte};
      if (hunting) begin
        if (win == 32'h00ff00ff) begin
          hunting = 0;
          cnt = 4;
          sum = 32'h0000_01fe;
          len = 16'hffff;
        end
      end else begin
        cnt++;
        if (cnt == 5) len[7:0] = txByte;
        if (cnt == 6) len[15:8] = txByte;
        if (cnt == 13) rotationPeriodCount[7:0] = txByte;
        if (cnt == 14) begin
          rotationPeriodCount[15:8] = txByte;
          scanRateValue = 1.0 / (0.00003160 * rotationPeriodCount);
        end
        if (cnt == 15) depthCount[7:0] = txByte;
        if (cnt == 16) begin
          depthCount[15:8] = txByte;
          depthMetres = DEPTH_SCALE * depthCount + DEPTH_OFFSET;
        end
        // first channel word of the first group only
        if (cnt == 21) wordLow = txByte;
        if (cnt == 22) firstWord = wordLow + txByte * 256.0;
        if (cnt == 23) firstWord = firstWord + txByte / 256.0;
        if (cnt <= len) sum += txByte;
        else rx = {txByte, rx[31:8]};
        if (cnt == len + 4) begin
          if (rx == sum) goodCount++;
          else badCount++;
          hunting = 1;
          win = 0;
        end
      end
    end
  end
endmodule // spmpf_host_sink

//--- dv/test_spectral_meter_packet_framer.sv
// testbench for the packet framer
`timescale 1ns/1ps
module test_spectral_meter_packet_framer;
  import spmpf_pkg::*;
  localparam int PAD = 3;
  localparam int TOTAL = LEN_INT + CHK_BYTES + PAD;
  logic        core_clk = 0;
  logic        resetn = 0;
  logic        ce = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        stall = 1;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        txValid;
  logic        txReady;
  logic [7:0]  txByte;
  logic [7:0]  expd[TOTAL];
  logic [31:0] rd;
  logic [31:0] sum;
  logic [15:0] st;
  logic [15:0] stPrev;
  logic        er;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;

  always #20 core_clk = ~core_clk;

  spmpf_framer #(.CYCLES_PER_MS(10), .PAD_BYTES(PAD)) DUT (
    .core_clk(core_clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txByte(txByte), .txValid(txValid), .txReady(txReady), .busy(busy)
  );

  spmpf_host_sink sink (
    .core_clk(core_clk), .resetn(resetn), .txByte(txByte), .txValid(txValid),
    .stall(stall), .txReady(txReady)
  );

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // a hang anywhere ends the run as a failure
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, expv);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [23:0] wv(input int i);
    return {8'(i * 7), 8'(i + 1), 8'(i ^ 8'h5a)};
  endfunction

  task automatic run_packet(input int n);
    // pointer back in range, so only busy can refuse the store write
    xfer(OFS_WADDR, 1'b1, 32'h0);
    xfer(OFS_CTRL, 1'b1, 32'h1);
    xfer(OFS_WDATA, 1'b1, 32'h0);
    chk(er, 1);
    while (sink.got.size() < n * TOTAL || busy !== 1'b0) @(posedge core_clk);
    chk(sink.goodCount, n);
  endtask

  initial begin
    for (int k = 0; k < TOTAL; k++) expd[k] = 8'h00;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(8'h28, 1'b1, 32'h1);
    chk(er, 1);
    xfer(OFS_WADDR, 1'b1, MEM_WORDS);
    chk(er, 1);
    xfer(OFS_STAMP, 1'b1, NUM_GROUPS);
    chk(er, 1);
    xfer(OFS_SERIAL, 1'b1, 32'h5a3c_9e71);
    xfer(OFS_ROT, 1'b1, 32'h1234);
    xfer(OFS_DEPTH, 1'b1, 32'h0abc);
    xfer(OFS_TEMP, 1'b1, 32'h010f);
    xfer(OFS_WADDR, 1'b1, 32'h0);
    for (int i = 0; i < MEM_WORDS; i++) xfer(OFS_WDATA, 1'b1, {8'h0, wv(i)});
    for (int g = 0; g < NUM_GROUPS; g++) begin
      repeat (25) @(posedge core_clk);
      xfer(OFS_STAMP, 1'b1, g);
    end
    expd[1] = 8'hff;
    expd[3] = 8'hff;
    {expd[5], expd[4]} = PKT_LEN;
    {expd[6], expd[7], expd[8], expd[9]} = 32'h5a3c_9e71;
    {expd[13], expd[12], expd[15], expd[14]} = 32'h1234_0abc;
    {expd[633], expd[632]} = 16'h010f;
    for (int i = 0; i < MEM_WORDS; i++) begin
      automatic int b = (i < REF_BASE) ? 20 + (i / NUM_CH) * GROUP_BYTES + 3 * (i % NUM_CH)
                                       : POS_REF + 3 * (i - REF_BASE);
      {expd[b + 1], expd[b], expd[b + 2]} = wv(i);
    end
    run_packet(1);
    chk(32'(sink.rotationPeriodCount), 32'h1234);
    chk(32'(sink.scanRateValue * 100.0), 32'd679);
    chk(32'(sink.depthMetres), 32'h0abc);
    chk(32'(sink.firstWord * 256.0), 32'd346);
    stPrev = 16'h0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      expd[18 + g * GROUP_BYTES] = sink.got[18 + g * GROUP_BYTES];
      expd[19 + g * GROUP_BYTES] = sink.got[19 + g * GROUP_BYTES];
      st = {expd[19 + g * GROUP_BYTES], expd[18 + g * GROUP_BYTES]};
      chk(32'(st > stPrev), 1);
      // captures lie 29 cycles apart, 10 cycles a millisecond
      chk(32'(g == 0 || (st - stPrev) inside {16'd2, 16'd3}), 1);
      stPrev = st;
    end
    sum = 32'h0;
    for (int k = 0; k < LEN_INT; k++) sum += expd[k];
    {expd[637], expd[636], expd[635], expd[634]} = sum;
    for (int k = 0; k < TOTAL; k++) chk(sink.got[k], expd[k]);
    // clock enable low must freeze the millisecond timer
    xfer(OFS_STAMP, 1'b0, 32'h0);
    stPrev = rd[15:0];
    ce <= 1'b0;
    repeat (50) @(posedge core_clk);
    ce <= 1'b1;
    xfer(OFS_STAMP, 1'b0, 32'h0);
    chk(32'(rd[15:0] - stPrev <= 16'd1), 1);
    xfer(OFS_CHKSUM, 1'b0, 32'h0);
    chk(rd, sum);
    stall <= 1'b0;
    run_packet(2);
    for (int k = 0; k < TOTAL; k++) chk(sink.got[TOTAL + k], expd[k]);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0002_0000);
    // repeat mode starts a packet by itself; cleared mid-packet, one only
    xfer(OFS_CTRL, 1'b1, 32'h2);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0002_0003);
    xfer(OFS_CTRL, 1'b1, 32'h0);
    while (sink.got.size() < 3 * TOTAL || busy !== 1'b0) @(posedge core_clk);
    chk(sink.goodCount, 3);
    for (int k = 0; k < TOTAL; k++) chk(sink.got[2 * TOTAL + k], expd[k]);
    report_and_stop;
  end
endmodule // test_spectral_meter_packet_framer
